// >>> verilog/sideband_ctrl.sv
// Processor sideband: power-good qualification, cold reset, straps, thermal trip.
// Assumes power_good_in, reset_n_in and the straps are driven by the platform
// sequencer and that temperature codes come from on-die monitors.
//
// The register offsets and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
module sideband_ctrl
  import sideband_pkg::*;
#(
  parameter int DIMM_COUNT = 4
) (
  input  wire logic                    ref_clk_in,             // 50 MHz clock.
  input  wire logic                    sys_rst_in,             // Sync reset, active high.
  input  wire logic                    power_good_in,          // Platform power-good.
  input  wire logic                    reset_n_in,             // Cold reset, active low.
  input  wire logic                    safe_boot_strap_in,     // Safe-boot strap.
  input  wire logic [1:0]              socket_index_strap_in,  // Socket index strap.
  input  wire logic                    firmware_agent_strap_in,// Firmware-agent strap.
  input  wire logic [7:0]              die_temp_in,            // Hottest die sensor.
  input  wire logic [7:0]              mem_if_temp_in,         // Memory interface temp.
  input  wire logic [8*DIMM_COUNT-1:0] dimm_temp_in,           // Module temps, side bus.
  output logic                         critical_overheat_n_out,// Trip, active low.
  output logic                         pll_enable_out,         // PLLs running.
  output logic                         exec_enable_out,        // Execution allowed.
  output logic                         cache_invalidate_out,   // Flush without write-back.
  output logic                         link_state_clear_out,   // Clear PLL/link/error state.
  output logic                         clock_gating_en_out,    // Clock gating allowed.
  output logic [6:0]                   thermal_bus_addr_out,   // Thermal bus address.
  output logic [1:0]                   node_id_out,            // Coherent-link node id.
  output logic                         legacy_socket_out,      // Legacy socket.
  output logic                         firmware_present_out,   // Bootable firmware here.
  output logic                         chipset_pcie_mode_out,  // Chipset link in PCIe mode.
  input  wire logic [ADDR_W-1:0]       s_axi_awaddr,           // Write address.
  input  wire logic                    s_axi_awvalid,          // Write address valid.
  output logic                         s_axi_awready,          // Write address ready.
  input  wire logic [DATA_W-1:0]       s_axi_wdata,            // Write data.
  input  wire logic [3:0]              s_axi_wstrb,            // Write strobes.
  input  wire logic                    s_axi_wvalid,           // Write data valid.
  output logic                         s_axi_wready,           // Write data ready.
  output logic [1:0]                   s_axi_bresp,            // Write response.
  output logic                         s_axi_bvalid,           // Write response valid.
  input  wire logic                    s_axi_bready,           // Write response ready.
  input  wire logic [ADDR_W-1:0]       s_axi_araddr,           // Read address.
  input  wire logic                    s_axi_arvalid,          // Read address valid.
  output logic                         s_axi_arready,          // Read address ready.
  output logic [DATA_W-1:0]            s_axi_rdata,            // Read data.
  output logic [1:0]                   s_axi_rresp,            // Read response.
  output logic                         s_axi_rvalid,           // Read data valid.
  input  wire logic                    s_axi_rready            // Read data ready.
);

  logic pg_sync;
  logic rst_n_sync;
  logic pg_prev_reg;
  logic rst_n_prev_reg;

  two_flop_sync #(.INIT(1'b0)) u_pg_sync (
    .ref_clk_in (ref_clk_in),
    .sys_rst_in (sys_rst_in),
    .level_in   (power_good_in),
    .level_out  (pg_sync)
  );

  two_flop_sync #(.INIT(1'b0)) u_rst_sync (
    .ref_clk_in (ref_clk_in),
    .sys_rst_in (sys_rst_in),
    .level_in   (reset_n_in),
    .level_out  (rst_n_sync)
  );

  wire pg_rise    = pg_sync & ~pg_prev_reg;
  wire in_reset   = ~rst_n_sync;
  wire rst_assert = ~rst_n_sync & rst_n_prev_reg;

  // Register file.
  logic [2:0] control_reg;
  logic [7:0] die_limit_reg;
  logic [7:0] mem_limit_reg;
  logic [7:0] dimm_limit_reg;

  // Thermal sources.
  logic [DIMM_COUNT-1:0] dimm_hot;
  genvar g;
  generate
    for (g = 0; g < DIMM_COUNT; g++) begin : g_dimm
      assign dimm_hot[g] = dimm_temp_in[8*g +: 8] > dimm_limit_reg;
    end
  endgenerate

  wire die_hot  = control_reg[CTL_DIE_EN] & (die_temp_in >= die_limit_reg);
  wire mem_hot  = control_reg[CTL_MEM_EN] & (mem_if_temp_in > mem_limit_reg);
  wire dimm_any = control_reg[CTL_DIMM_EN] & (|dimm_hot);
  wire trip_src = die_hot | mem_hot | dimm_any;

  // Trip is armed only after power-good and while out of reset.
  wire trip_set = pg_sync & rst_n_sync & trip_src;

  power_state_e state_reg;
  power_state_e state_next;
  logic         tripped_reg;
  logic         safe_boot_reg;
  logic [1:0]   socket_reg;
  logic         fw_agent_reg;
  logic [2:0]   cause_reg;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      PWR_OFF:     if (pg_sync) state_next = PWR_QUAL;
      PWR_QUAL:    if (rst_n_sync) state_next = PWR_RUN;
      PWR_RUN:     if (trip_set) state_next = PWR_TRIPPED;
                   else if (in_reset) state_next = PWR_QUAL;
      PWR_TRIPPED: if (in_reset) state_next = PWR_QUAL;
    endcase
    if (!pg_sync) begin
      state_next = PWR_OFF;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      state_reg      <= PWR_OFF;
      pg_prev_reg    <= 1'b0;
      rst_n_prev_reg <= 1'b0;
    end else begin
      state_reg      <= state_next;
      pg_prev_reg    <= pg_sync;
      rst_n_prev_reg <= rst_n_sync;
    end
  end

  // The trip latch holds through power-good loss; only reset releases it.
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      tripped_reg <= 1'b0;
      cause_reg   <= 3'h0;
    end else if (trip_set) begin
      tripped_reg <= 1'b1;
      cause_reg   <= cause_reg | {dimm_any, mem_hot, die_hot};
    end else if (in_reset) begin
      tripped_reg <= 1'b0;
      cause_reg   <= 3'h0;
    end
  end

  // Straps are captured once on the power-good rising edge.
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      safe_boot_reg <= 1'b0;
      socket_reg    <= 2'h0;
      fw_agent_reg  <= 1'b0;
    end else if (pg_rise) begin
      safe_boot_reg <= safe_boot_strap_in;
      socket_reg    <= socket_index_strap_in;
      fw_agent_reg  <= firmware_agent_strap_in;
    end
  end

  wire is_legacy = (socket_reg == LEGACY_SOCKET);

  // Outputs, all registered.
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      critical_overheat_n_out <= 1'b1;
      pll_enable_out          <= 1'b0;
      exec_enable_out         <= 1'b0;
      cache_invalidate_out    <= 1'b1;
      link_state_clear_out    <= 1'b1;
      clock_gating_en_out     <= 1'b1;
      thermal_bus_addr_out    <= THERMAL_BUS_BASE;
      node_id_out             <= 2'h0;
      legacy_socket_out       <= 1'b0;
      firmware_present_out    <= 1'b0;
      chipset_pcie_mode_out   <= 1'b0;
    end else begin
      critical_overheat_n_out <= ~(tripped_reg | trip_set);
      pll_enable_out          <= pg_sync & ~tripped_reg & ~trip_set;
      exec_enable_out         <= (state_next == PWR_RUN) & ~tripped_reg & ~trip_set;
      cache_invalidate_out    <= in_reset;
      link_state_clear_out    <= ~pg_sync;
      clock_gating_en_out     <= ~safe_boot_reg;
      thermal_bus_addr_out    <= THERMAL_BUS_BASE | {5'h00, socket_reg};
      node_id_out             <= socket_reg;
      legacy_socket_out       <= is_legacy & fw_agent_reg;
      firmware_present_out    <= fw_agent_reg;
      chipset_pcie_mode_out   <= ~is_legacy;
    end
  end

  // AXI4-Lite slave. Address and data may arrive in either order.
  logic              aw_held_reg;
  logic              w_held_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [DATA_W-1:0] wdata_reg;
  logic [3:0]        wstrb_reg;

  wire aw_fire  = s_axi_awvalid & s_axi_awready;
  wire w_fire   = s_axi_wvalid & s_axi_wready;
  wire do_write = aw_held_reg & w_held_reg & ~s_axi_bvalid;
  wire wr_known = (awaddr_reg == OFS_CONTROL) | (awaddr_reg == OFS_DIE_LIMIT) |
                  (awaddr_reg == OFS_MEM_LIMIT) | (awaddr_reg == OFS_DIMM_LIM);
  wire ar_fire  = s_axi_arvalid & s_axi_arready;

  logic [DATA_W-1:0] rd_mux;
  logic              rd_ok;
  always_comb begin
    rd_ok  = 1'b1;
    rd_mux = '0;
    unique case (s_axi_araddr)
      OFS_CONTROL:   rd_mux = {29'h0, control_reg};
      OFS_STATUS:    rd_mux = {24'h0, cause_reg, state_reg, tripped_reg, pg_sync, rst_n_sync};
      OFS_STRAPS:    rd_mux = {28'h0, fw_agent_reg, socket_reg, safe_boot_reg};
      OFS_DIE_LIMIT: rd_mux = {24'h0, die_limit_reg};
      OFS_MEM_LIMIT: rd_mux = {24'h0, mem_limit_reg};
      OFS_DIMM_LIM:  rd_mux = {24'h0, dimm_limit_reg};
      OFS_IDENT:     rd_mux = IDENT_VALUE;
      default:       rd_ok  = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      aw_held_reg    <= 1'b0;
      w_held_reg     <= 1'b0;
      awaddr_reg     <= '0;
      wdata_reg      <= '0;
      wstrb_reg      <= 4'h0;
      s_axi_awready  <= 1'b1;
      s_axi_wready   <= 1'b1;
      s_axi_bvalid   <= 1'b0;
      s_axi_bresp    <= RESP_OKAY;
      control_reg    <= CONTROL_RST;
      die_limit_reg  <= DIE_LIMIT_RST;
      mem_limit_reg  <= MEM_LIMIT_RST;
      dimm_limit_reg <= DIMM_LIM_RST;
    end else begin
      if (aw_fire) begin
        aw_held_reg   <= 1'b1;
        awaddr_reg    <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (w_fire) begin
        w_held_reg   <= 1'b1;
        wdata_reg    <= s_axi_wdata;
        wstrb_reg    <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_known ? RESP_OKAY : RESP_SLVERR;
        if (wstrb_reg[0]) begin
          if (awaddr_reg == OFS_CONTROL)   control_reg    <= wdata_reg[2:0];
          if (awaddr_reg == OFS_DIE_LIMIT) die_limit_reg  <= wdata_reg[7:0];
          if (awaddr_reg == OFS_MEM_LIMIT) mem_limit_reg  <= wdata_reg[7:0];
          if (awaddr_reg == OFS_DIMM_LIM)  dimm_limit_reg <= wdata_reg[7:0];
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (ar_fire) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_mux;
      s_axi_rresp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  sequence s_tripped;
    !critical_overheat_n_out;
  endsequence

  a_trip_holds_latch: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    s_tripped ##1 rst_n_sync ##0 $past(rst_n_sync) |-> !critical_overheat_n_out)
    else $error("trip output released without reset");
  a_trip_needs_pg: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    $fell(critical_overheat_n_out) |-> $past(pg_sync))
    else $error("trip asserted before power-good");
  a_trip_stops_pll: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    s_tripped |-> !pll_enable_out && !exec_enable_out)
    else $error("PLL or execution active during trip");
  a_die_trip_fast: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    pg_sync && rst_n_sync && die_hot |=> !critical_overheat_n_out)
    else $error("die over-temperature did not trip");
  a_dimm_trip_fast: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    pg_sync && rst_n_sync && dimm_any |=> !critical_overheat_n_out)
    else $error("module over-temperature did not trip");
  a_retrip_after_reset: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    $rose(rst_n_sync) && pg_sync && trip_src |=> !critical_overheat_n_out)
    else $error("no re-trip after reset release while hot");
  a_reset_clears_trip: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    in_reset ##1 in_reset |=> critical_overheat_n_out)
    else $error("reset did not release trip output");
  a_cache_inval: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    in_reset |=> cache_invalidate_out)
    else $error("cache invalidate missing during reset");
  a_strap_capture: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    pg_rise |=> safe_boot_reg == $past(safe_boot_strap_in) ##1 clock_gating_en_out == !safe_boot_reg)
    else $error("safe-boot strap not captured at power-good");

endmodule

// >>> verilog/sideband_pkg.sv
// Constants and types shared by the processor sideband block.
// Assumes a single 50 MHz clock and an AXI4-Lite register bus with 32-bit data.
package sideband_pkg;

  localparam int          CLK_HZ        = 50_000_000;
  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 32;

  // Register byte offsets.
  localparam logic [7:0]  OFS_CONTROL   = 8'h00;
  localparam logic [7:0]  OFS_STATUS    = 8'h04;
  localparam logic [7:0]  OFS_STRAPS    = 8'h08;
  localparam logic [7:0]  OFS_DIE_LIMIT = 8'h0c;
  localparam logic [7:0]  OFS_MEM_LIMIT = 8'h10;
  localparam logic [7:0]  OFS_DIMM_LIM  = 8'h14;
  localparam logic [7:0]  OFS_IDENT     = 8'h18;

  // Control register fields.
  localparam int          CTL_DIE_EN    = 0;
  localparam int          CTL_MEM_EN    = 1;
  localparam int          CTL_DIMM_EN   = 2;

  // Reset values of the limit registers (degrees, 8-bit codes) and of the control register.
  localparam logic [7:0]  DIE_LIMIT_RST = 8'h69;
  localparam logic [7:0]  MEM_LIMIT_RST = 8'h5f;
  localparam logic [7:0]  DIMM_LIM_RST  = 8'h55;
  localparam logic [2:0]  CONTROL_RST   = 3'h7;

  // Socket configuration values.
  localparam int          NODE_IDS_PER_SOCKET = 1;
  localparam int          TRACKER_ENTRIES     = 128;
  localparam logic [6:0]  THERMAL_BUS_BASE    = 7'h30;
  localparam logic [1:0]  LEGACY_SOCKET       = 2'h0;

  // Arbitrary identity value, not tied to any real part.
  localparam logic [31:0] IDENT_VALUE   = 32'h5eb0_0001;

  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  typedef enum logic [1:0] {PWR_OFF, PWR_QUAL, PWR_RUN, PWR_TRIPPED} power_state_e;

endpackage

// >>> verilog/two_flop_sync.sv
// Two-flop synchroniser for one level.
// Assumes the input may change at any time relative to ref_clk_in.
`timescale 1ns/1ps
module two_flop_sync #(
  parameter logic INIT = 1'b0
) (
  input  wire logic ref_clk_in,  // System clock.
  input  wire logic sys_rst_in,  // Synchronous reset, active high.
  input  wire logic level_in,    // Asynchronous level.
  output logic      level_out    // Synchronised level.
);
  logic first_reg;

  // The first stage feeds only the second stage.
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      first_reg <= INIT;
      level_out <= INIT;
    end else begin
      first_reg <= level_in;
      level_out <= first_reg;
    end
  end
endmodule

// >>> bench/platform_seq.sv
// Behavioural platform sequencer that drives power-good and cold reset.
// Assumes the bench requests supplies and reset release; straps come from the bench.
`timescale 1ns/1ps
module platform_seq #(
  parameter int SETTLE = 8
) (
  input  wire logic ref_clk_in,             // System clock.
  input  wire logic supply_on_in,           // Bench asks for supplies.
  input  wire logic run_in,                 // Bench asks for reset release.
  input  wire logic critical_overheat_n_in, // Trip from the processor.
  output logic      power_good_out,         // Power-good to the processor.
  output logic      reset_n_out             // Cold reset, active low.
);
  logic [7:0] settle_reg  = 8'h00;
  logic       tripped_reg = 1'b0;

  // A trip keeps supplies off until the request is withdrawn, so a hot part
  // is never powered straight back up.
  always_ff @(posedge ref_clk_in) begin
    if (!supply_on_in) begin
      tripped_reg <= 1'b0;
    end else if (!critical_overheat_n_in) begin
      tripped_reg <= 1'b1;
    end
    if (!supply_on_in || !critical_overheat_n_in || tripped_reg) begin
      settle_reg <= 8'h00;
    end else if (settle_reg != 8'(SETTLE)) begin
      settle_reg <= settle_reg + 8'h01;
    end
  end

  assign power_good_out = (settle_reg == 8'(SETTLE));
  assign reset_n_out    = run_in;
endmodule

// >>> bench/testbench.sv
// Self-checking bench for the processor sideband block.
// Assumes platform_seq drives power-good and reset; registers are reached over AXI4-Lite.
`timescale 1ns/1ps
module testbench;
  import sideband_pkg::*;
  typedef struct packed {logic [33:0] v; logic [33:0] m;} note_s;
  logic        ref_clk_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic        power_good_in, reset_n_in, critical_overheat_n_out, pll_enable_out;
  logic        exec_enable_out, cache_invalidate_out, link_state_clear_out, clock_gating_en_out;
  logic        legacy_socket_out, firmware_present_out, chipset_pcie_mode_out;
  logic [6:0]  thermal_bus_addr_out;
  logic [1:0]  node_id_out, s_axi_bresp, s_axi_rresp;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_rdata;
  logic        safe_boot_strap_in = 1'b0;
  logic        firmware_agent_strap_in = 1'b0;
  logic [1:0]  socket_index_strap_in = 2'h0;
  logic [7:0]  die_temp_in = 8'h00;
  logic [7:0]  mem_if_temp_in = 8'h00;
  logic [31:0] dimm_temp_in = 32'h0;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        supply_on = 1'b0, run = 1'b0, probe = 1'b0, c_safe = 1'b0, c_fw = 1'b0;
  logic [1:0]  c_sock = 2'h0;
  logic [7:0]  die_lim = DIE_LIMIT_RST;
  int          n_errors = 0, n_tests = 0, k;
  note_s       exp_q[$];
  wire  [17:0] pins = {critical_overheat_n_out, pll_enable_out, exec_enable_out,
                       cache_invalidate_out, link_state_clear_out, clock_gating_en_out,
                       thermal_bus_addr_out, node_id_out, legacy_socket_out,
                       firmware_present_out, chipset_pcie_mode_out};

  platform_seq #(.SETTLE(8)) u_plat (.ref_clk_in, .supply_on_in(supply_on), .run_in(run),
    .critical_overheat_n_in(critical_overheat_n_out), .power_good_out(power_good_in),
    .reset_n_out(reset_n_in));
  sideband_ctrl #(.DIMM_COUNT(4)) dut (.ref_clk_in, .sys_rst_in, .power_good_in, .reset_n_in,
    .safe_boot_strap_in, .socket_index_strap_in, .firmware_agent_strap_in, .die_temp_in,
    .mem_if_temp_in, .dimm_temp_in, .critical_overheat_n_out, .pll_enable_out,
    .exec_enable_out, .cache_invalidate_out, .link_state_clear_out, .clock_gating_en_out,
    .thermal_bus_addr_out, .node_id_out, .legacy_socket_out, .firmware_present_out,
    .chipset_pcie_mode_out, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);

  initial begin
    forever #10 ref_clk_in = ~ref_clk_in;
  end

  task automatic idle(int n);
    repeat (n) @(posedge ref_clk_in);
  endtask

  task automatic chk(string nm, logic [33:0] seen, note_s n);
    n_tests++;
    if ((seen & n.m) !== (n.v & n.m)) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, n.v & n.m, seen & n.m);
    end
  endtask

  // Results are compared in arrival order against the notes left by the driver.
  always @(posedge ref_clk_in) begin
    if (s_axi_rvalid && s_axi_rready) begin
      chk("read", {s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
    end
    if (s_axi_bvalid && s_axi_bready) begin
      chk("write", {s_axi_bresp, 32'h0}, exp_q.pop_front());
    end
    if (probe) chk("pins", {16'h0, pins}, exp_q.pop_front());
  end

  task automatic look(logic pg, logic rn, logic tr);
    exp_q.push_back('{{16'h0, ~tr, pg & ~tr, pg & rn & ~tr, ~rn, ~pg, ~c_safe,
                     THERMAL_BUS_BASE | {5'h0, c_sock}, c_sock,
                     c_sock == LEGACY_SOCKET && c_fw, c_fw, c_sock != LEGACY_SOCKET},
                     {34{1'b1}}});
    probe <= 1'b1;
    @(posedge ref_clk_in);
    probe <= 1'b0;
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] r);
    exp_q.push_back('{{r, 32'h0}, {2'h3, 32'h0}});
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge ref_clk_in);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    @(posedge ref_clk_in);
  endtask

  // Data is only compared on an OKAY answer; an error answer carries no defined data.
  task automatic rd(logic [7:0] a, logic [31:0] d, logic [1:0] r);
    exp_q.push_back('{{r, d}, {2'h3, ((r == RESP_OKAY) ? 32'hffffffff : 32'h0)}});
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge ref_clk_in);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    @(posedge ref_clk_in);
  endtask

  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    idle(20000);
    n_errors++;
    wrap_up;
  end

  initial begin
    void'($urandom(3634));
    idle(16);
    sys_rst_in <= 1'b0;
    idle(2);
    look(0, 0, 0);
    rd(OFS_STATUS, 32'h0, RESP_OKAY);
    rd(OFS_CONTROL, {29'h0, CONTROL_RST}, RESP_OKAY);
    rd(OFS_MEM_LIMIT, {24'h0, MEM_LIMIT_RST}, RESP_OKAY);
    rd(OFS_DIMM_LIM, {24'h0, DIMM_LIM_RST}, RESP_OKAY);
    rd(OFS_IDENT, IDENT_VALUE, RESP_OKAY);
    rd(8'h1c, 32'h0, RESP_SLVERR);
    rd(OFS_DIE_LIMIT, {24'h0, DIE_LIMIT_RST}, RESP_OKAY);
    die_lim = 8'h20 + 8'($urandom_range(0, 192));
    wr(OFS_DIE_LIMIT, {24'h0, die_lim}, RESP_OKAY);
    rd(OFS_DIE_LIMIT, {24'h0, die_lim}, RESP_OKAY);
    wr(OFS_STATUS, 32'h1, RESP_SLVERR);
    wr(OFS_IDENT, 32'h0, RESP_SLVERR);
    run <= 1'b1;
    die_temp_in <= 8'hff;
    idle(10);
    look(0, 1, 0);
    die_temp_in <= 8'h00;
    for (k = 0; k < 4; k++) begin
      supply_on <= 1'b0;
      run <= 1'b0;
      idle(12);
      look(0, 0, 0);
      c_sock = 2'(k);
      c_fw = 1'($urandom);
      c_safe = 1'($urandom);
      socket_index_strap_in <= c_sock;
      firmware_agent_strap_in <= c_fw;
      safe_boot_strap_in <= c_safe;
      supply_on <= 1'b1;
      idle(20);
      look(1, 0, 0);
      rd(OFS_STRAPS, {28'h0, c_fw, c_sock, c_safe}, RESP_OKAY);
      run <= 1'b1;
      idle(6);
      look(1, 1, 0);
      rd(OFS_STATUS, 32'h13, RESP_OKAY);
      socket_index_strap_in <= ~c_sock;
      firmware_agent_strap_in <= ~c_fw;
      safe_boot_strap_in <= ~c_safe;
      idle(6);
      look(1, 1, 0);
    end
    socket_index_strap_in <= c_sock;
    firmware_agent_strap_in <= c_fw;
    safe_boot_strap_in <= c_safe;
    for (k = 0; k < 3; k++) begin
      case (k)
        0: die_temp_in <= die_lim - 8'h01;
        1: mem_if_temp_in <= MEM_LIMIT_RST;
        default: dimm_temp_in <= {4{DIMM_LIM_RST}};
      endcase
      idle(8);
      look(1, 1, 0);
      case (k)
        0: die_temp_in <= die_lim;
        1: mem_if_temp_in <= MEM_LIMIT_RST + 8'h01;
        default: dimm_temp_in[8*($urandom%4) +: 8] <= DIMM_LIM_RST + 8'h01;
      endcase
      idle(10);
      look(0, 1, 1);
      rd(OFS_STATUS, 32'h05 | (32'h20 << k), RESP_OKAY);
      die_temp_in <= 8'h00;
      mem_if_temp_in <= 8'h00;
      dimm_temp_in <= 32'h0;
      idle(6);
      look(0, 1, 1);
      run <= 1'b0;
      supply_on <= 1'b0;
      idle(6);
      look(0, 0, 0);
      supply_on <= 1'b1;
      run <= 1'b1;
      idle(24);
      look(1, 1, 0);
    end
    die_temp_in <= 8'hff;
    idle(10);
    look(0, 1, 1);
    run <= 1'b0;
    supply_on <= 1'b0;
    idle(6);
    look(0, 0, 0);
    supply_on <= 1'b1;
    idle(24);
    look(1, 0, 0);
    run <= 1'b1;
    idle(10);
    look(0, 1, 1);
    die_temp_in <= 8'h00;
    idle(4);
    wrap_up;
  end
endmodule
